// File: pkg/port_pkg.sv
// Shared constants for the host/test shared serial port
package port_pkg;
    localparam int          CMD_BITS      = 8;
    localparam int          CMD_READ_BIT  = 7;
    localparam int          ADDR_BITS     = 4;
    localparam int          DATA_BITS     = 16;
    localparam int          FRAME_BITS    = CMD_BITS + DATA_BITS;
    localparam int          REG_COUNT     = 16;
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam int          STATUS_ADDR   = 0;
    localparam int          IR_BITS       = 2;
    localparam logic [1:0]  IR_CAPTURE    = 2'h1;
    localparam logic [1:0]  IR_BYPASS     = 2'h3;
    localparam logic [1:0]  IR_SCAN       = 2'h1;
    localparam int          SCAN_BITS     = 8;
    localparam int          SCAN_ADDR     = 1;
    localparam int          CLK_SYS_NS    = 10;
    localparam int          SCLK_PERIOD_NS = 160;
    localparam int          SCLK_HALF_CYC = (SCLK_PERIOD_NS + 2 * CLK_SYS_NS - 1) / (2 * CLK_SYS_NS);
endpackage : port_pkg

// File: pkg/shared_port_if.sv
// Pins shared between the device end and the host or tester end
`timescale 1ns/100ps
interface shared_port_if;
    logic mode_test;
    logic reset_pin_n;
    logic loop_output_enable;
    logic sclk_tck;
    logic cs_tms;
    logic serial_in_or_test_in;
    logic serial_out_or_test_out;
    logic serial_out_oe;
    logic loop_serial_output_p;
    logic loop_serial_output_n;
    logic loop_serial_output_oe;
    logic serial_out_level;

    // Pulled high when nobody drives it
    assign serial_out_level = serial_out_oe ? serial_out_or_test_out : 1'b1;

    modport device (
        input  mode_test, reset_pin_n, loop_output_enable, sclk_tck, cs_tms, serial_in_or_test_in,
        output serial_out_or_test_out, serial_out_oe,
        output loop_serial_output_p, loop_serial_output_n, loop_serial_output_oe
    );
    modport host (
        output mode_test, reset_pin_n, loop_output_enable, sclk_tck, cs_tms, serial_in_or_test_in,
        input  serial_out_level
    );
endinterface : shared_port_if

// File: logic/pin_sampler.sv
// Two-stage synchroniser with edge detection for asynchronous pins
`timescale 1ns/100ps
module pin_sampler #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // Pins
    input  wire logic [W-1:0] pin,
    // Sampled
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign level = stage2;
    assign rise  = stage2 & ~stage3;
    assign fall  = ~stage2 & stage3;
endmodule : pin_sampler

// File: logic/device_port.sv
// Device end: shared host register port or boundary-scan port
`timescale 1ns/100ps
// What this block does
// - Loop enable low floats loop outputs
// - Host-mode reset defaults blocks, floats outputs
// - Far side keeps reset high normally
// - Test-mode reset defaults, holds test sequence
// - Reset release restarts test sequence from reset state
// - Select high gives pins to boundary scan
// - Select low gives pins to host port
// - Host mode: select pin is active-low chip select
// - Test mode: select pin is active-high TMS
// - Unused host port: chip select tied high
// - Host mode: output pin shifts register reads
// - Host writes address and data serially
// - Test mode: output pin is TDO
// - Tester drives TDI on input pin
// - Shared clock is burst clock or TCK
// - Words move synchronously with serial clock
module device_port
    import port_pkg::*;
(
    // Clock and reset
    input  wire logic                                 clk_sys,
    input  wire logic                                 nrst,
    // Shared pins
    shared_port_if.device                             port,
    // User side
    input  wire logic                                 loop_data,
    input  wire logic [DATA_BITS-1:0]                 status_word,
    output logic      [REG_COUNT-1:0][DATA_BITS-1:0]  config_regs,
    output logic                                      test_active,
    output logic                                      held_in_reset
);
    typedef enum {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
        TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } tap_state_t;
    typedef enum {
        SP_CMD, SP_DATA, SP_DONE
    } serial_phase_t;

    logic [5:0]           pin_level;
    logic [5:0]           pin_rise;
    logic [5:0]           pin_fall;
    logic                 reset_s;
    logic                 mode_s;
    logic                 loop_en_s;
    logic                 tms_s;
    logic                 tdi_s;
    logic                 clk_rise;
    logic                 clk_fall;
    logic                 func_reset;
    logic                 host_sel;
    logic                 tap_hold;
    logic                 last_cmd_bit;
    logic                 last_data_bit;
    logic                 cmd_read;
    logic [ADDR_BITS-1:0] cmd_addr;
    logic [DATA_BITS-1:0] read_value;
    logic                 tap_shifting;
    logic                 tap_bit;
    logic                 next_serial_out;
    logic                 next_serial_oe;
    logic                 next_loop_oe;
    tap_state_t           tap;
    tap_state_t           next_tap;
    serial_phase_t        phase;
    logic [4:0]           bit_cnt;
    logic [CMD_BITS-1:0]  cmd_shift;
    logic [DATA_BITS-1:0] wr_shift;
    logic [DATA_BITS-1:0] rd_shift;
    logic                 host_bit;
    logic [IR_BITS-1:0]   ir;
    logic [IR_BITS-1:0]   ir_shift;
    logic                 bypass_bit;
    logic [SCAN_BITS-1:0] scan_shift;
    logic                 tdo_bit;

    pin_sampler #(
        .W (6)
    ) u_pins (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .pin     ({port.reset_pin_n, port.mode_test, port.loop_output_enable,
                   port.sclk_tck, port.cs_tms, port.serial_in_or_test_in}),
        .level   (pin_level),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // Sampled pins
    assign reset_s    = pin_level[5];
    assign mode_s     = pin_level[4];
    assign loop_en_s  = pin_level[3];
    assign clk_rise   = pin_rise[2];
    assign clk_fall   = pin_fall[2];
    assign tms_s      = pin_level[1];
    assign tdi_s      = pin_level[0];
    assign func_reset = !reset_s;
    assign host_sel   = !mode_s && !tms_s && !func_reset;
    assign tap_hold   = !mode_s || func_reset;

    // Host command decode
    assign last_cmd_bit  = (phase == SP_CMD) && (bit_cnt == 5'(CMD_BITS - 1));
    assign last_data_bit = (phase == SP_DATA) && (bit_cnt == 5'(DATA_BITS - 1));
    assign cmd_read      = last_cmd_bit ? cmd_shift[CMD_READ_BIT-1] : cmd_shift[CMD_READ_BIT];
    assign cmd_addr      = last_cmd_bit ? {cmd_shift[ADDR_BITS-2:0], tdi_s} : cmd_shift[ADDR_BITS-1:0];
    assign read_value    = (cmd_addr == ADDR_BITS'(STATUS_ADDR)) ? status_word : config_regs[cmd_addr];

    // Host serial register port
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            phase     <= SP_CMD;
            bit_cnt   <= 5'h00;
            cmd_shift <= '0;
            wr_shift  <= '0;
            rd_shift  <= '0;
            host_bit  <= 1'b0;
        end
        else if (!host_sel)
        begin
            phase    <= SP_CMD;
            bit_cnt  <= 5'h00;
            host_bit <= 1'b0;
        end
        else
        begin
            if (clk_rise && phase == SP_CMD)
            begin
                cmd_shift <= {cmd_shift[CMD_BITS-2:0], tdi_s};
                bit_cnt   <= last_cmd_bit ? 5'h00 : bit_cnt + 5'h01;
                if (last_cmd_bit)
                begin
                    phase    <= SP_DATA;
                    rd_shift <= read_value;
                end
            end
            else if (clk_rise && phase == SP_DATA)
            begin
                wr_shift <= {wr_shift[DATA_BITS-2:0], tdi_s};
                bit_cnt  <= bit_cnt + 5'h01;
                if (last_data_bit)
                begin
                    phase <= SP_DONE;
                end
            end
            if (clk_fall && phase == SP_DATA && cmd_read)
            begin
                host_bit <= rd_shift[DATA_BITS-1];
                rd_shift <= {rd_shift[DATA_BITS-2:0], 1'b0};
            end
        end
    end

    // Register store
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            config_regs <= {REG_COUNT{REG_RESET}};
        end
        else if (func_reset)
        begin
            config_regs <= {REG_COUNT{REG_RESET}};
        end
        else if (host_sel && clk_rise && last_data_bit && !cmd_read)
        begin
            config_regs[cmd_addr] <= {wr_shift[DATA_BITS-2:0], tdi_s};
        end
    end

    // Test access state sequence
    always_comb
    begin
        next_tap = tap;
        case (tap)
            TAP_RESET:  next_tap = tms_s ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tap = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: next_tap = tms_s ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tap = tms_s ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: next_tap = tms_s ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
            default:    next_tap = TAP_RESET;
        endcase
    end

    assign tap_shifting = (tap == TAP_SH_DR) || (tap == TAP_SH_IR);
    assign tap_bit      = (tap == TAP_SH_IR) ? ir_shift[0] : ((ir == IR_BYPASS) ? bypass_bit : scan_shift[0]);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tap        <= TAP_RESET;
            ir         <= IR_BYPASS;
            ir_shift   <= '0;
            bypass_bit <= 1'b0;
            scan_shift <= '0;
            tdo_bit    <= 1'b0;
        end
        else if (tap_hold)
        begin
            tap     <= TAP_RESET;
            ir      <= IR_BYPASS;
            tdo_bit <= 1'b0;
        end
        else
        begin
            if (clk_rise)
            begin
                tap <= next_tap;
                case (tap)
                    TAP_RESET:  ir <= IR_BYPASS;
                    TAP_CAP_IR: ir_shift <= IR_CAPTURE;
                    TAP_SH_IR:  ir_shift <= {tdi_s, ir_shift[IR_BITS-1:1]};
                    TAP_UPD_IR: ir <= ir_shift;
                    TAP_CAP_DR:
                    begin
                        bypass_bit <= 1'b0;
                        scan_shift <= config_regs[SCAN_ADDR][SCAN_BITS-1:0];
                    end
                    TAP_SH_DR:
                    begin
                        bypass_bit <= tdi_s;
                        scan_shift <= {tdi_s, scan_shift[SCAN_BITS-1:1]};
                    end
                    default:    ir <= ir;
                endcase
            end
            if (clk_fall)
            begin
                tdo_bit <= tap_bit;
            end
        end
    end

    // Pin drivers
    assign next_serial_out = mode_s ? tdo_bit : host_bit;
    assign next_serial_oe  = mode_s ? (!func_reset && tap_shifting) : host_sel;
    assign next_loop_oe    = loop_en_s && !(func_reset && !mode_s);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            port.serial_out_or_test_out <= 1'b0;
            port.serial_out_oe          <= 1'b0;
            port.loop_serial_output_p   <= 1'b0;
            port.loop_serial_output_n   <= 1'b1;
            port.loop_serial_output_oe  <= 1'b0;
            test_active                 <= 1'b0;
            held_in_reset               <= 1'b1;
        end
        else
        begin
            port.serial_out_or_test_out <= next_serial_out;
            port.serial_out_oe          <= next_serial_oe;
            port.loop_serial_output_p   <= loop_data;
            port.loop_serial_output_n   <= !loop_data;
            port.loop_serial_output_oe  <= next_loop_oe;
            test_active                 <= mode_s;
            held_in_reset               <= func_reset;
        end
    end
endmodule : device_port

// File: logic/host_port.sv
// Host or tester end: drives the shared serial or test port
`timescale 1ns/100ps
module host_port
    import port_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // Shared pins
    shared_port_if.host               port,
    // Static controls
    input  wire logic                 test_mode,
    input  wire logic                 hold_reset,
    input  wire logic                 loop_enable,
    // Register requests
    input  wire logic                 req_valid,
    input  wire logic                 req_write,
    input  wire logic [ADDR_BITS-1:0] req_addr,
    input  wire logic [DATA_BITS-1:0] req_data,
    output logic                      req_ready,
    output logic                      rsp_valid,
    output logic [DATA_BITS-1:0]      rsp_data,
    // Test clock requests
    input  wire logic                 tap_valid,
    input  wire logic                 tap_tms,
    input  wire logic                 tap_tdi,
    output logic                      tap_rsp_valid,
    output logic                      tap_tdo
);
    typedef enum {
        H_IDLE, H_LOW, H_HIGH, H_GAP
    } host_state_t;

    logic                  sdo_s;
    logic                  half_done;
    logic                  frame_end;
    logic                  start_reg;
    logic                  start_tap;
    host_state_t           state;
    logic [7:0]            timer;
    logic [4:0]            bits_left;
    logic [FRAME_BITS-1:0] tx;
    logic [DATA_BITS-1:0]  rx;
    logic                  is_tap;

    pin_sampler #(
        .W (1)
    ) u_sdo (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .pin     (port.serial_out_level),
        .level   (sdo_s),
        .rise    (),
        .fall    ()
    );

    assign half_done = (timer == 8'(HALF_CYC - 1));
    assign frame_end = (bits_left == 5'h01);
    assign start_reg = (state == H_IDLE) && req_valid && !test_mode && !hold_reset;
    assign start_tap = (state == H_IDLE) && tap_valid && test_mode;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state         <= H_IDLE;
            timer         <= 8'h00;
            bits_left     <= 5'h00;
            tx            <= '0;
            rx            <= '0;
            is_tap        <= 1'b0;
            req_ready     <= 1'b0;
            rsp_valid     <= 1'b0;
            rsp_data      <= '0;
            tap_rsp_valid <= 1'b0;
            tap_tdo       <= 1'b0;
            port.mode_test            <= 1'b0;
            port.reset_pin_n          <= 1'b0;
            port.loop_output_enable   <= 1'b0;
            port.sclk_tck             <= 1'b1;
            port.cs_tms               <= 1'b1;
            port.serial_in_or_test_in <= 1'b0;
        end
        else
        begin
            port.mode_test          <= test_mode;
            port.reset_pin_n        <= !hold_reset;
            port.loop_output_enable <= loop_enable;
            rsp_valid               <= 1'b0;
            tap_rsp_valid           <= 1'b0;
            req_ready               <= 1'b0;
            timer                   <= half_done ? 8'h00 : timer + 8'h01;
            case (state)
                H_IDLE:
                begin
                    timer <= 8'h00;
                    if (!test_mode)
                    begin
                        port.cs_tms <= 1'b1;
                    end
                    if (start_reg)
                    begin
                        req_ready <= 1'b1;
                        is_tap    <= 1'b0;
                        tx        <= {!req_write, (CMD_BITS - ADDR_BITS - 1)'(0), req_addr, req_data};
                        bits_left <= 5'(FRAME_BITS);
                        port.cs_tms <= 1'b0;
                        port.sclk_tck <= 1'b0;
                        port.serial_in_or_test_in <= !req_write;
                        state     <= H_LOW;
                    end
                    else if (start_tap)
                    begin
                        is_tap    <= 1'b1;
                        tx        <= {tap_tdi, (FRAME_BITS - 1)'(0)};
                        bits_left <= 5'h01;
                        port.cs_tms <= tap_tms;
                        port.sclk_tck <= 1'b0;
                        port.serial_in_or_test_in <= tap_tdi;
                        state     <= H_LOW;
                    end
                end
                H_LOW:
                begin
                    if (half_done)
                    begin
                        rx            <= {rx[DATA_BITS-2:0], sdo_s};
                        port.sclk_tck <= 1'b1;
                        state         <= H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    if (half_done && frame_end)
                    begin
                        if (!is_tap)
                        begin
                            port.cs_tms <= 1'b1;
                        end
                        state <= H_GAP;
                    end
                    else if (half_done)
                    begin
                        tx            <= {tx[FRAME_BITS-2:0], 1'b0};
                        bits_left     <= bits_left - 5'h01;
                        port.serial_in_or_test_in <= tx[FRAME_BITS-2];
                        port.sclk_tck <= 1'b0;
                        state         <= H_LOW;
                    end
                end
                H_GAP:
                begin
                    if (half_done)
                    begin
                        rsp_valid     <= !is_tap;
                        rsp_data      <= rx;
                        tap_rsp_valid <= is_tap;
                        tap_tdo       <= rx[0];
                        state         <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule : host_port

// File: dv/shared_port_sva.sv
// Assertions on the shared host/test port pins
`timescale 1ns/100ps
module shared_port_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Pins
    input wire logic mode_test,
    input wire logic reset_pin_n,
    input wire logic loop_output_enable,
    input wire logic sclk_tck,
    input wire logic cs_tms,
    input wire logic serial_out_or_test_out,
    input wire logic serial_out_oe,
    input wire logic loop_serial_output_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence host_sel;
        (!mode_test && !cs_tms && reset_pin_n) [*5];
    endsequence
    sequence host_rst;
        (!mode_test && !reset_pin_n) [*4];
    endsequence
    sequence tck_idle;
        (mode_test && reset_pin_n && sclk_tck) [*6];
    endsequence
    a_loop_float: assert property (!loop_output_enable [*4] |-> !loop_serial_output_oe)
        else $error("loop outputs driven while disabled");
    a_loop_drive: assert property ((loop_output_enable && reset_pin_n) [*5] |-> loop_serial_output_oe)
        else $error("loop outputs floating while enabled");
    a_host_rst_float: assert property (host_rst |-> !serial_out_oe && !loop_serial_output_oe)
        else $error("outputs driven during host reset");
    a_test_rst_quiet: assert property ((mode_test && !reset_pin_n) [*4] |-> !serial_out_oe)
        else $error("test output driven during reset");
    a_cs_idle_float: assert property ((!mode_test && cs_tms) [*4] |-> !serial_out_oe)
        else $error("serial output driven while deselected");
    a_cs_drive: assert property (host_sel |-> serial_out_oe)
        else $error("serial output floating while selected");
    a_out_low_phase: assert property (serial_out_oe && $past(serial_out_oe)
        && $changed(serial_out_or_test_out) |-> !sclk_tck)
        else $error("serial output changed in clock high phase");
    a_tap_hold: assert property (tck_idle |=> $stable(serial_out_oe))
        else $error("test output enable moved without test clock");
endmodule : shared_port_sva

// File: dv/host_test_port_select_tb.sv
// Testbench joining the device end and the host end
`timescale 1ns/100ps
module host_test_port_select_tb;
    import port_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic test_mode = 1'b0;
    logic hold_reset = 1'b0;
    logic loop_enable = 1'b1;
    logic loop_data = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [ADDR_BITS-1:0] req_addr = 4'h0;
    logic [DATA_BITS-1:0] req_data = 16'h0;
    logic [DATA_BITS-1:0] status_word = 16'h1E2D;
    logic tap_valid = 1'b0;
    logic tap_tms = 1'b1;
    logic tap_tdi = 1'b0;
    logic req_ready, rsp_valid, tap_rsp_valid, tap_tdo, test_active, held_in_reset;
    logic [DATA_BITS-1:0] rsp_data, q;
    logic [REG_COUNT-1:0][DATA_BITS-1:0] config_regs;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] scan_exp = 8'hB6;

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) loop_data <= #1 ~loop_data;

    shared_port_if port ();
    device_port device_port_inst (.clk_sys, .nrst, .port(port.device), .loop_data, .status_word,
        .config_regs, .test_active, .held_in_reset);
    host_port host_port_inst (.clk_sys, .nrst, .port(port.host), .test_mode, .hold_reset, .loop_enable,
        .req_valid, .req_write, .req_addr, .req_data, .req_ready, .rsp_valid, .rsp_data,
        .tap_valid, .tap_tms, .tap_tdi, .tap_rsp_valid, .tap_tdo);
    shared_port_sva shared_port_sva_inst (.clk_sys, .nrst, .mode_test(port.mode_test),
        .reset_pin_n(port.reset_pin_n), .loop_output_enable(port.loop_output_enable),
        .sclk_tck(port.sclk_tck), .cs_tms(port.cs_tms), .serial_out_or_test_out(port.serial_out_or_test_out),
        .serial_out_oe(port.serial_out_oe), .loop_serial_output_oe(port.loop_serial_output_oe));

    task automatic summarize;
        $display("checks=%0d errors=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    // Hold the request until the answer pulse, then release
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_data = d;
        for (int n = 0; n < 600 && !rsp_valid; n++) step(1);
        chk({15'h0, rsp_valid}, 16'h1);
        q = rsp_data;
        req_valid = 1'b0;
        step(1);
    endtask : xfer

    task automatic refuse;
        logic r;
        r = 1'b0;
        req_valid = 1'b1;
        repeat (30)
        begin
            step(1);
            r = r | req_ready | rsp_valid;
        end
        req_valid = 1'b0;
        chk({15'h0, r}, 16'h0);
    endtask : refuse

    // One test clock; eo[1] asks for a check of the returned bit against eo[0]
    task automatic tap(input logic ms, input logic di, input logic [1:0] eo);
        tap_valid = 1'b1;
        tap_tms = ms;
        tap_tdi = di;
        for (int n = 0; n < 100 && !tap_rsp_valid; n++) step(1);
        chk({15'h0, tap_rsp_valid}, 16'h1);
        if (eo[1]) chk({15'h0, tap_tdo}, {15'h0, eo[0]});
        tap_valid = 1'b0;
        step(1);
    endtask : tap

    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        step(6);
        xfer(1'b1, 4'h3, 16'hA5C3);
        xfer(1'b1, 4'hF, 16'h5A3C);
        chk(config_regs[3], 16'hA5C3);
        xfer(1'b0, 4'h3, 16'h0); chk(q, 16'hA5C3);
        xfer(1'b0, 4'h0, 16'h0); chk(q, 16'h1E2D);
        xfer(1'b0, 4'hF, 16'h0); chk(q, 16'h5A3C);
        loop_enable = 1'b0;
        step(8); chk({15'h0, port.loop_serial_output_oe}, 16'h0);
        loop_enable = 1'b1;
        step(8); chk({15'h0, port.loop_serial_output_oe}, 16'h1);
        chk({15'h0, port.loop_serial_output_p ^ port.loop_serial_output_n}, 16'h1);
        hold_reset = 1'b1;
        step(8); chk({15'h0, port.loop_serial_output_oe}, 16'h0);
        chk({15'h0, held_in_reset}, 16'h1); chk(config_regs[15], 16'h0);
        refuse();
        hold_reset = 1'b0;
        step(8); chk({15'h0, held_in_reset}, 16'h0);
        xfer(1'b1, 4'h3, 16'hC3A5);
        xfer(1'b1, 4'h1, {8'h00, scan_exp});
        test_mode = 1'b1;
        step(8); chk({15'h0, test_active}, 16'h1);
        refuse();
        repeat (5) tap(1'b1, 1'b0, 2'h0);
        tap(1'b0, 1'b0, 2'h0); tap(1'b1, 1'b0, 2'h0); tap(1'b0, 1'b0, 2'h0); tap(1'b0, 1'b0, 2'h0);
        tap(1'b0, 1'b1, 2'h2); tap(1'b0, 1'b0, 2'h3);
        tap(1'b0, 1'b1, 2'h2); tap(1'b0, 1'b0, 2'h3);
        // Load the scan instruction, then shift out the captured register
        repeat (4) tap(1'b1, 1'b0, 2'h0);
        repeat (2) tap(1'b0, 1'b0, 2'h0);
        tap(1'b0, 1'b1, 2'h3);
        tap(1'b1, 1'b0, 2'h2);
        repeat (2) tap(1'b1, 1'b0, 2'h0);
        repeat (2) tap(1'b0, 1'b0, 2'h0);
        for (int i = 0; i < 8; i++) tap(1'b0, 1'b0, {1'b1, scan_exp[i]});
        hold_reset = 1'b1;
        step(8); chk({15'h0, held_in_reset}, 16'h1); chk(config_regs[3], 16'h0);
        hold_reset = 1'b0;
        step(8);
        tap(1'b0, 1'b0, 2'h3);
        tap(1'b1, 1'b0, 2'h0); tap(1'b0, 1'b0, 2'h0); tap(1'b0, 1'b0, 2'h0);
        tap(1'b0, 1'b1, 2'h2); tap(1'b0, 1'b0, 2'h3);
        test_mode = 1'b0;
        step(8); chk({15'h0, test_active}, 16'h0);
        chk({15'h0, port.serial_out_oe}, 16'h0);
        summarize();
    end
endmodule : host_test_port_select_tb
